//--- core/fpc_counter.sv
// Purpose: 3-bit fast pulse counter chained with an 8/16-bit timer, timed output pin
// Assumes: Avalon-MM slave on clk_sys; pulse pin slower than clk_sys/2
// Notes:   one-cycle waitrequest on every access; unmapped reads give zero
//
// Notes on behaviour
// - high match buffer follows data unless running
// - high match on byte, or all 16 bits
// - low capture latches low count byte
// - high capture latches high count byte
// - fast counter is 3 bits wide
// - chained timer steps on fast overflow
// - chained timer is free-running, cleared only when stopped
// - pin changes in same cycle as target
// - low capture also stores carry and fine count
// - target match sets flag, requests interrupt
// - fast counter runs with low byte run
// - enable clear makes pin follow latch
// - enable write re-arms and freezes pin
// - after match pin follows latch again
// - port test bit 2 enables timed output
// - 8-bit mode 11 bits, 16-bit mode 19
// - one match per fast control write
// - carry and fine capture are read-only
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/10ps

module fpc_counter
  import fpc_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // external pulse source
  input  wire logic              fast_pulse_input,
  // neighbouring logic on clk_sys
  input  wire logic              prescale_tick,
  input  wire logic              low_capture_event,
  input  wire logic              high_capture_event,
  input  wire logic              port_latch_data,
  input  wire logic              port_dir_out,
  // timed output pin
  output logic                   timed_output_pin_o,
  output logic                   timed_output_pin_oe,
  // interrupt requests and configuration to neighbours
  output logic                   low_irq,
  output logic                   high_irq,
  output logic      [7:0]        ext_irq01_cfg,
  output logic      [7:0]        ext_irq23_cfg,
  output logic      [7:0]        input_select_cfg
);

  ////////////////////////////////////////////////////////////////////////
  // address decode helper

  // true when a byte address selects the register at this index
  function automatic logic fpc_sel(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
    fpc_sel = (addr == {idx, 2'b00});
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic        pulse_meta_r;
  logic        pulse_sync_r;
  logic        pulse_prev_r;
  logic        ack_r;
  logic [7:0]  tc_r;
  logic [7:0]  low_cnt_r;
  logic [7:0]  high_cnt_r;
  logic [7:0]  low_match_data_r;
  logic [7:0]  high_match_data_r;
  logic [7:0]  low_buf_r;
  logic [7:0]  high_buf_r;
  logic [7:0]  low_capture_r;
  logic [7:0]  high_capture_r;
  logic        timed_output_enable_r;
  logic [7:0]  irq01_r;
  logic [7:0]  irq23_r;
  logic [7:0]  isl_r;
  logic        fc_en_r;
  logic [2:0]  fine_cmp_r;
  logic        carry_cap_r;
  logic [2:0]  fine_cap_r;
  logic [2:0]  fine_r;
  logic        armed_r;
  logic        freeze_r;
  logic        hold_r;
  logic [31:0] rdata_r;
  logic [7:0]  rd_byte;

  ////////////////////////////////////////////////////////////////////////
  // pulse pin synchroniser

  // two flops first
  // the pin is asynchronous, so only the second flop is read;
  // the third keeps the previous level for edge detection,
  // so each pin phase must last longer than one system cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pulse_meta_r <= 1'b0;
      pulse_sync_r <= 1'b0;
      pulse_prev_r <= 1'b0;
    end else begin
      pulse_meta_r <= fast_pulse_input;
      pulse_sync_r <= pulse_meta_r;
      pulse_prev_r <= pulse_sync_r;
    end
  end

  // one-cycle pulse per rising edge of the synchronised pin;
  // reset leaves both flops low, so no false edge follows
  wire pulse_edge = pulse_sync_r & ~pulse_prev_r;

  ////////////////////////////////////////////////////////////////////////
  // bus access decode

  wire acc      = avs_read | avs_write;
  wire wr_take  = avs_write & ack_r;
  wire wr_tc    = wr_take & fpc_sel(avs_address, IDX_TIMER_CONTROL);
  wire wr_lmd   = wr_take & fpc_sel(avs_address, IDX_LOW_MATCH);
  wire wr_hmd   = wr_take & fpc_sel(avs_address, IDX_HIGH_MATCH);
  wire wr_pt    = wr_take & fpc_sel(avs_address, IDX_PORT_TEST);
  wire wr_i01   = wr_take & fpc_sel(avs_address, IDX_EXT_IRQ01);
  wire wr_i23   = wr_take & fpc_sel(avs_address, IDX_EXT_IRQ23);
  wire wr_isl   = wr_take & fpc_sel(avs_address, IDX_INPUT_SELECT);
  wire wr_fc    = wr_take & fpc_sel(avs_address, IDX_FAST_CTRL);
  wire [7:0] wd = avs_writedata[7:0];

  // waitrequest is high in the first cycle of every access;
  // that cycle registers the read byte, the second one
  // commits a write and hands read data to the master
  assign avs_waitrequest = acc & ~ack_r;
  assign avs_readdata    = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // mode and count-enable decode

  wire low_run   = tc_r[TC_LOW_RUN];
  wire high_run  = tc_r[TC_HIGH_RUN];
  wire wide      = tc_r[TC_WIDE];
  wire chained   = fc_en_r;

  // no run bit of its own; with the enable clear it rests
  // at zero and the low byte keeps its ordinary clock
  // fast counter steps only while low byte runs
  wire fine_tick = chained & low_run & pulse_edge;
  wire fine_ovf  = fine_tick & (fine_r == FINE_MAX);
  wire [2:0] fine_nxt = !(chained && low_run) ? RST_FINE : (fine_tick ? fine_r + 3'h1 : fine_r);

  // chained low byte steps on fast overflow
  wire low_tick  = chained ? fine_ovf : (low_run & (tc_r[TC_LOW_EXT] ? pulse_edge : prescale_tick));
  wire low_wrap  = low_tick & (low_cnt_r == BYTE_MAX);
  // in 8-bit chained mode the high byte keeps its own
  // prescaled clock, match and reload
  // wide mode carries low into high, else high counts alone
  wire high_tick = wide ? low_wrap : (high_run & prescale_tick);

  ////////////////////////////////////////////////////////////////////////
  // ordinary match signals

  wire low_eq  = (low_cnt_r == low_buf_r);
  wire high_eq = (high_cnt_r == high_buf_r);
  wire match_l = ~chained & low_tick & low_eq & (~wide | high_eq);
  // high byte alone, or all sixteen bits
  wire match_h = wide ? match_l : (high_tick & high_eq);

  ////////////////////////////////////////////////////////////////////////
  // target compare on the chained count

  wire [19:0] chain_cnt  = wide ? {1'b0, high_cnt_r, low_cnt_r, fine_r} : {9'h000, low_cnt_r, fine_r};
  wire [16:0] tgt_base   = wide ? {1'b0, high_match_data_r, low_match_data_r} : {9'h000, low_match_data_r};
  wire [16:0] tgt_inc    = tgt_base + 17'h00001;
  wire [19:0] tgt_full   = {tgt_inc, fine_cmp_r};
  // target uses the match data, not the buffers, so a new
  // value acts at once; the sum wraps at the chain width
  // and software keeps it above the present count
  // target is (match + 1) * 8 + compare
  wire [19:0] target     = wide ? {1'b0, tgt_full[18:0]} : {9'h000, tgt_full[10:0]};
  // combinational hit lets the pin move in the cycle the
  // count arrives; the arming clears at the next edge
  // only one hit per arming
  wire        nk_hit     = chained & low_run & armed_r & (chain_cnt == target);

  ////////////////////////////////////////////////////////////////////////
  // flag set terms

  // the low match is gated off while chained, and so is the high
  // one in wide mode, so there the flags carry only the target hit
  // target sets low flag, both in wide mode
  wire set_lflag = match_l | nk_hit;
  wire set_hflag = match_h | (nk_hit & wide);

  ////////////////////////////////////////////////////////////////////////
  // bus handshake and read data
  // ack_r marks the second cycle of an access and never
  // stays up, so back-to-back requests each wait once

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ack_r   <= 1'b0;
      rdata_r <= RST_WORD;
    end else begin
      ack_r <= acc & ~ack_r;
      if (avs_read && !ack_r) begin
        rdata_r <= {24'h000000, rd_byte};
      end
    end
  end

  // read multiplexer, unmapped addresses read zero
  // no two indices share a byte address
  always_comb begin
    rd_byte = RST_BYTE;
    if (fpc_sel(avs_address, IDX_TIMER_CONTROL)) rd_byte = tc_r;
    if (fpc_sel(avs_address, IDX_LOW_COUNT))     rd_byte = low_cnt_r;
    if (fpc_sel(avs_address, IDX_HIGH_COUNT))    rd_byte = high_cnt_r;
    if (fpc_sel(avs_address, IDX_LOW_MATCH))     rd_byte = low_match_data_r;
    if (fpc_sel(avs_address, IDX_HIGH_MATCH))    rd_byte = high_match_data_r;
    if (fpc_sel(avs_address, IDX_LOW_CAPTURE))   rd_byte = low_capture_r;
    if (fpc_sel(avs_address, IDX_HIGH_CAPTURE))  rd_byte = high_capture_r;
    if (fpc_sel(avs_address, IDX_PORT_TEST))     rd_byte = {5'h00, timed_output_enable_r, 2'h0};
    if (fpc_sel(avs_address, IDX_EXT_IRQ01))     rd_byte = irq01_r;
    if (fpc_sel(avs_address, IDX_EXT_IRQ23))     rd_byte = irq23_r;
    if (fpc_sel(avs_address, IDX_INPUT_SELECT))  rd_byte = isl_r;
    if (fpc_sel(avs_address, IDX_FAST_CTRL))     rd_byte = {fc_en_r, fine_cmp_r, carry_cap_r, fine_cap_r};
  end

  ////////////////////////////////////////////////////////////////////////
  // control and configuration registers
  // irq and input-select bytes are plain storage; the port
  // test byte keeps only its timed-output enable bit

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tc_r                  <= RST_BYTE;
      low_match_data_r      <= RST_BYTE;
      high_match_data_r     <= RST_BYTE;
      timed_output_enable_r <= 1'b0;
      irq01_r               <= RST_BYTE;
      irq23_r               <= RST_BYTE;
      isl_r                 <= RST_BYTE;
    end else begin
      if (wr_tc) begin
        tc_r <= wd;
      end
      // match flags: hardware set wins over software clear
      tc_r[TC_LOW_FLAG]  <= set_lflag | (wr_tc ? wd[TC_LOW_FLAG] : tc_r[TC_LOW_FLAG]);
      tc_r[TC_HIGH_FLAG] <= set_hflag | (wr_tc ? wd[TC_HIGH_FLAG] : tc_r[TC_HIGH_FLAG]);
      if (wr_lmd) low_match_data_r <= wd;
      if (wr_hmd) high_match_data_r <= wd;
      if (wr_pt)  timed_output_enable_r <= wd[PT_TIMED_OUT_EN];
      if (wr_i01) irq01_r <= wd;
      if (wr_i23) irq23_r <= wd;
      if (wr_isl) isl_r <= wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timer counts and match buffers

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      low_cnt_r  <= RST_BYTE;
      high_cnt_r <= RST_BYTE;
      low_buf_r  <= RST_BYTE;
      high_buf_r <= RST_BYTE;
      fine_r     <= RST_FINE;
    end else begin
      fine_r <= fine_nxt;
      // the chained timer never reloads: match_l is forced low
      // while the fast counter is enabled, match_h too in wide mode
      // stopped bytes rest at zero; match reloads them in plain mode
      if (!low_run || match_l) low_cnt_r <= RST_BYTE;
      else if (low_tick)       low_cnt_r <= low_cnt_r + 8'h01;
      if (!high_run || match_h) high_cnt_r <= RST_BYTE;
      else if (high_tick)       high_cnt_r <= high_cnt_r + 8'h01;
      if (!low_run || match_l) low_buf_r <= low_match_data_r;
      // high buffer tracks data while stopped
      if (!high_run || match_h) high_buf_r <= high_match_data_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture registers, no reset: contents undefined until first capture
  // the low capture takes the count before the edge; an overflow
  // in that cycle is reported through the carry bit instead

  always_ff @(posedge clk_sys) begin
    if (low_capture_event)  low_capture_r <= low_cnt_r;
    if (high_capture_event) high_capture_r <= high_cnt_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // fast counter control and timed output state

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fc_en_r     <= 1'b0;
      fine_cmp_r  <= RST_FINE;
      carry_cap_r <= 1'b0;
      fine_cap_r  <= RST_FINE;
      armed_r     <= 1'b0;
      freeze_r    <= 1'b0;
      hold_r      <= 1'b0;
    end else begin
      // only enable and compare take bus data
      if (wr_fc) begin
        fc_en_r    <= wd[FC_ENABLE];
        fine_cmp_r <= wd[FC_CMP_LSB +: 3];
      end
      // carry, fine field and low byte give the count after
      // the edge: software adds one to the byte on carry
      // carry plus fine count with low capture
      if (low_capture_event) begin
        carry_cap_r <= fine_ovf;
        fine_cap_r  <= fine_nxt;
      end
      // any write restarts the search; one with the enable
      // clear disarms and hands the pin back to the latch
      // enable write re-arms and freezes present level
      if (wr_fc) begin
        armed_r  <= wd[FC_ENABLE];
        freeze_r <= wd[FC_ENABLE];
        hold_r   <= timed_output_pin_o;
      // match releases pin to the latch
      end else if (nk_hit) begin
        armed_r  <= 1'b0;
        freeze_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timed output pin and interrupt requests

  // frozen pin comes from the hold flop; at the hit it takes
  // the latch value that software loaded after arming
  // hit releases the pin combinationally, same cycle
  wire frozen = timed_output_enable_r & fc_en_r & freeze_r & ~nk_hit;
  assign timed_output_pin_o  = frozen ? hold_r : port_latch_data;
  assign timed_output_pin_oe = port_dir_out;

  // levels that stay up until software clears the flag
  // interrupt request while flag and enable set
  assign low_irq  = tc_r[TC_LOW_FLAG] & tc_r[TC_LOW_IE];
  assign high_irq = tc_r[TC_HIGH_FLAG] & tc_r[TC_HIGH_IE];

  // configuration bytes exported as levels
  assign ext_irq01_cfg    = irq01_r;
  assign ext_irq23_cfg    = irq23_r;
  assign input_select_cfg = isl_r;

endmodule

//--- core/fpc_pkg.sv
// Purpose: shared constants of the fast pulse counter and its chained timer
// Assumes: registers are 8 bits wide, each in one aligned 32-bit bus word
// Notes:   byte address of a register is four times its index
package fpc_pkg;

  // register indices and byte address width
  localparam logic [15:0] IDX_TIMER_CONTROL    = 16'hFE10;
  localparam logic [15:0] IDX_LOW_COUNT        = 16'hFE12;
  localparam logic [15:0] IDX_HIGH_COUNT       = 16'hFE13;
  localparam logic [15:0] IDX_LOW_MATCH        = 16'hFE14;
  localparam logic [15:0] IDX_HIGH_MATCH       = 16'hFE15;
  localparam logic [15:0] IDX_LOW_CAPTURE      = 16'hFE16;
  localparam logic [15:0] IDX_HIGH_CAPTURE     = 16'hFE17;
  localparam logic [15:0] IDX_PORT_TEST        = 16'hFE47;
  localparam logic [15:0] IDX_EXT_IRQ01        = 16'hFE5D;
  localparam logic [15:0] IDX_EXT_IRQ23        = 16'hFE5E;
  localparam logic [15:0] IDX_INPUT_SELECT     = 16'hFE5F;
  localparam logic [15:0] IDX_FAST_CTRL        = 16'hFE7D;
  localparam int          ADDR_W               = 18;

  // timer_control fields
  localparam int          TC_HIGH_RUN          = 7;
  localparam int          TC_LOW_RUN           = 6;
  localparam int          TC_WIDE              = 5;
  localparam int          TC_LOW_EXT           = 4;
  localparam int          TC_HIGH_FLAG         = 3;
  localparam int          TC_HIGH_IE           = 2;
  localparam int          TC_LOW_FLAG          = 1;
  localparam int          TC_LOW_IE            = 0;

  // fast_counter_control fields
  localparam int          FC_ENABLE            = 7;
  localparam int          FC_CMP_LSB           = 4;
  localparam int          FC_CARRY             = 3;
  localparam int          FC_CAP_LSB           = 0;

  // port_test_control field
  localparam int          PT_TIMED_OUT_EN      = 2;

  // reset values and count limits
  localparam logic [7:0]  RST_BYTE             = 8'h00;
  localparam logic [2:0]  RST_FINE             = 3'h0;
  localparam logic [2:0]  FINE_MAX             = 3'h7;
  localparam logic [7:0]  BYTE_MAX             = 8'hFF;
  localparam logic [31:0] RST_WORD             = 32'h0000_0000;

endpackage

//--- tb/fpc_counter_asserts.sv
// Purpose: concurrent checks on the ports of the fast pulse counter
// Assumes: everything seen on clk_sys, bus writes shadowed from taken cycles
// Notes:   enable bits are shadowed so the pin rule can be judged from ports
`timescale 1ns/10ps
module fpc_counter_asserts
  import fpc_pkg::*;
(
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              resetn,
  // register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  // pins and neighbours
  input wire logic              port_latch_data,
  input wire logic              port_dir_out,
  input wire logic              timed_output_pin_o,
  input wire logic              timed_output_pin_oe,
  input wire logic [7:0]        ext_irq01_cfg
);
  ////////////////////////////////////////////////////////////////////////////////
  // taken bus cycles and shadow of the two enables
  wire  any_req = avs_read || avs_write;
  wire  wr_take = avs_write && !avs_waitrequest;
  wire  rd_take = avs_read && !avs_waitrequest;
  wire  arm_wr  = wr_take && avs_address == {IDX_FAST_CTRL, 2'b00} && avs_writedata[FC_ENABLE];
  logic pt_en_r;
  logic fe_en_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pt_en_r <= 1'b0;
      fe_en_r <= 1'b0;
    end else if (wr_take && avs_address == {IDX_PORT_TEST, 2'b00}) begin
      pt_en_r <= avs_writedata[PT_TIMED_OUT_EN];
    end else if (wr_take && avs_address == {IDX_FAST_CTRL, 2'b00}) begin
      fe_en_r <= avs_writedata[FC_ENABLE];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  // bus handshake, one wait cycle per access; read data upper bits and unmapped read
  a_wait_start: assert property (!any_req ##1 any_req |-> avs_waitrequest)
    else $error("no wait cycle at start of access");
  a_wait_next: assert property (any_req && !avs_waitrequest |=> !any_req || avs_waitrequest)
    else $error("back-to-back access skipped its wait cycle");
  a_wait_one: assert property (any_req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait cycle longer than one");
  a_rdata_upper: assert property (rd_take |-> avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_hole_zero: assert property (rd_take && avs_address == {16'hFE11, 2'b00} |-> avs_readdata == RST_WORD)
    else $error("unmapped read not zero");
  // pin behaviour and config export
  a_pin_follow: assert property (!(pt_en_r && fe_en_r) |-> timed_output_pin_o == port_latch_data)
    else $error("pin not following latch while timed output off");
  a_oe_dir: assert property (timed_output_pin_oe == port_dir_out)
    else $error("pin enable differs from direction");
  a_arm_freeze: assert property (arm_wr && pt_en_r |=> $stable(timed_output_pin_o))
    else $error("arming write moved the pin");
  a_cfg_store: assert property (wr_take && avs_address == {IDX_EXT_IRQ01, 2'b00}
                                |=> ext_irq01_cfg == $past(avs_writedata[7:0]))
    else $error("config port not updated by write");
  // main scenarios reached
  c_hole: cover property (rd_take && avs_address == {16'hFE11, 2'b00});
  c_arm: cover property (arm_wr && pt_en_r);
  c_frozen: cover property (pt_en_r && fe_en_r && timed_output_pin_o != port_latch_data);
endmodule

bind fpc_counter fpc_counter_asserts u_chk (.clk_sys, .resetn, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .port_latch_data, .port_dir_out,
  .timed_output_pin_o, .timed_output_pin_oe, .ext_irq01_cfg);

//--- tb/fpc_pulse_src.sv
// Purpose: external pulse source driving the fast pulse pin
// Assumes: 48 ns period, phase unrelated to clk_sys
// Notes:   pin rests low between bursts, so no stray edges are counted
`timescale 1ns/10ps
module fpc_pulse_src (
  // pulse pin toward the counter
  output logic fast_pulse_input
);
  initial fast_pulse_input = 1'b0;
  // n rising edges, each phase 24 ns, well above two system cycles
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      #24 fast_pulse_input = 1'b1;
      #24 fast_pulse_input = 1'b0;
    end
  endtask
endmodule

//--- tb/tb_top.sv
// Purpose: self-checking bench of the fast pulse counter
// Assumes: chained count modelled as an integer of pulses sent
// Notes:   pin compared with the model after each burst of a target search, flags and captures after each hit
`timescale 1ns/10ps
module tb_top
  import fpc_pkg::*;
;
  localparam logic [15:0] RST_A [0:8] = '{IDX_TIMER_CONTROL, IDX_LOW_COUNT, IDX_HIGH_COUNT, IDX_LOW_MATCH,
    IDX_HIGH_MATCH, IDX_EXT_IRQ01, IDX_EXT_IRQ23, IDX_INPUT_SELECT, IDX_FAST_CTRL};
  localparam logic [15:0] CFG_A [0:2] = '{IDX_EXT_IRQ01, IDX_EXT_IRQ23, IDX_INPUT_SELECT};
  logic              clk_sys            = 1'b0;
  logic              resetn             = 1'b0;
  logic [ADDR_W-1:0] avs_address        = '0;
  logic              avs_read           = 1'b0;
  logic              avs_write          = 1'b0;
  logic [31:0]       avs_writedata      = '0;
  logic              prescale_tick      = 1'b0;
  logic              low_capture_event  = 1'b0;
  logic              high_capture_event = 1'b0;
  logic              port_latch_data    = 1'b0;
  logic              port_dir_out       = 1'b1;
  wire  [31:0]       avs_readdata;
  wire               avs_waitrequest;
  wire               fast_pulse_input;
  wire               timed_output_pin_o;
  wire               timed_output_pin_oe;
  wire               low_irq;
  wire               high_irq;
  wire  [7:0]        ext_irq01_cfg;
  wire  [7:0]        ext_irq23_cfg;
  wire  [7:0]        input_select_cfg;
  int                failures           = 0;
  int                cmp_count          = 0;
  int                cnt                = 0;
  int                tgt;
  logic [7:0]        lf                 = 8'h3D;
  logic [7:0]        cfg_v [0:2];
  logic [7:0]        mt;
  logic [2:0]        cp;
  logic              lv;
  logic [7:0]        fq;
  logic [7:0]        gq;
  ////////////////////////////////////////////////////////////////////////////////
  // design, pulse source, clock
  fpc_counter uut (.clk_sys, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .fast_pulse_input, .prescale_tick, .low_capture_event, .high_capture_event,
    .port_latch_data, .port_dir_out, .timed_output_pin_o, .timed_output_pin_oe, .low_irq, .high_irq,
    .ext_irq01_cfg, .ext_irq23_cfg, .input_select_cfg);
  fpc_pulse_src src (.fast_pulse_input);
  always #2.5 clk_sys = !clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic wrap_up;
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one bus access, request held until waitrequest is seen low
  task automatic bus(input logic we, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    avs_address   <= {a, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write     <= we;
    avs_read      <= !we;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, e, q);
  endtask
  task automatic cap;
    @(posedge clk_sys);
    low_capture_event  <= 1'b1;
    high_capture_event <= 1'b1;
    @(posedge clk_sys);
    low_capture_event  <= 1'b0;
    high_capture_event <= 1'b0;
  endtask
  // arm, then flip latch, run to one short of target, then onto it
  task automatic hit_test;
    lv = port_latch_data;
    wr(IDX_FAST_CTRL, {1'b1, cp, 4'hF});
    @(posedge clk_sys) port_latch_data <= !lv;
    src.burst(tgt - cnt - 1);
    cnt = tgt - 1;
    repeat (4) @(posedge clk_sys);
    chk("frozen pin", {7'h00, lv}, {7'h00, timed_output_pin_o});
    src.burst(1);
    cnt = tgt;
    repeat (4) @(posedge clk_sys);
    chk("pin at target", {7'h00, !lv}, {7'h00, timed_output_pin_o});
    @(posedge clk_sys) port_latch_data <= lv;
    repeat (2) @(posedge clk_sys);
    chk("pin after target", {7'h00, lv}, {7'h00, timed_output_pin_o});
    cap();
    // software view: capture byte plus carry, times 8, plus fine field
    bus(1'b0, IDX_LOW_CAPTURE, 8'h00, gq);
    bus(1'b0, IDX_FAST_CTRL, 8'h00, fq);
    chk("corrected count", 8'(cnt), 8'((gq + fq[FC_CARRY]) * 8 + fq[2:0]));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #400000;
    failures++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 9; i++) rdc(RST_A[i], RST_BYTE, "reset value");
    rdc(16'hFE11, RST_BYTE, "unmapped read");
    for (int i = 0; i < 3; i++) begin
      lf = lfsr(lf);
      cfg_v[i] = lf;
      wr(CFG_A[i], lf);
      rdc(CFG_A[i], lf, "config readback");
    end
    chk("irq01 port", cfg_v[0], ext_irq01_cfg);
    chk("irq23 port", cfg_v[1], ext_irq23_cfg);
    chk("select port", cfg_v[2], input_select_cfg);
    wr(IDX_LOW_COUNT, 8'h55);
    rdc(IDX_LOW_COUNT, RST_BYTE, "read-only count");
    wr(IDX_PORT_TEST, BYTE_MAX);
    rdc(IDX_PORT_TEST, 8'h04, "port test");
    wr(IDX_TIMER_CONTROL, 8'h51);
    // two target searches in the 11-bit chain
    for (int i = 0; i < 2; i++) begin
      mt  = 8'(2 + 2 * i);
      cp  = 3'(3 - 2 * i);
      tgt = (mt + 1) * 8 + cp;
      wr(IDX_LOW_MATCH, mt);
      hit_test();
      rdc(IDX_TIMER_CONTROL, 8'h53, "low flag");
      chk("low irq", 8'h01, {7'h00, low_irq});
      wr(IDX_TIMER_CONTROL, 8'h51);
      rdc(IDX_LOW_CAPTURE, 8'(cnt / 8), "low capture");
      rdc(IDX_FAST_CTRL, {1'b1, cp, 1'b0, 3'(cnt % 8)}, "fine capture");
      rdc(IDX_LOW_COUNT, 8'(cnt / 8), "low count");
    end
    // high byte keeps its own prescaled count beside the 11-bit chain
    wr(IDX_HIGH_MATCH, 8'h05);
    wr(IDX_TIMER_CONTROL, 8'hD1);
    repeat (3) begin
      @(posedge clk_sys) prescale_tick <= 1'b1;
      @(posedge clk_sys) prescale_tick <= 1'b0;
    end
    rdc(IDX_HIGH_COUNT, 8'h03, "prescaled high count");
    // stopped timer ignores pulses
    wr(IDX_TIMER_CONTROL, RST_BYTE);
    cnt = 0;
    src.burst(8);
    repeat (4) @(posedge clk_sys);
    rdc(IDX_LOW_COUNT, RST_BYTE, "stopped count");
    // 19-bit chain, target across the high byte
    wr(IDX_HIGH_MATCH, 8'h01);
    wr(IDX_LOW_MATCH, 8'h00);
    wr(IDX_TIMER_CONTROL, 8'hF4);
    cp  = 3'h5;
    tgt = 257 * 8 + 5;
    hit_test();
    rdc(IDX_TIMER_CONTROL, 8'hFE, "both flags");
    chk("high irq", 8'h01, {7'h00, high_irq});
    chk("low irq off", 8'h00, {7'h00, low_irq});
    rdc(IDX_HIGH_CAPTURE, 8'(cnt / 2048), "high capture");
    rdc(IDX_LOW_CAPTURE, 8'((cnt / 8) % 256), "wide low capture");
    wrap_up();
  end
endmodule
